// ==== src/tpf_pkg.sv ====
package tpf_pkg;
  // printed offsets are register indices; the byte address is index * 4
  localparam logic [15:0] PAIR0_FFCR_IDX = 16'h1105;
  localparam logic [15:0] PAIR1_FFCR_IDX = 16'h110D;
  localparam logic [15:0] PAIR2_MOD_IDX = 16'h1114;
  localparam logic [31:0] PAIR0_FFCR_ADDR = {14'h0000, PAIR0_FFCR_IDX, 2'h0};
  localparam logic [31:0] PAIR1_FFCR_ADDR = {14'h0000, PAIR1_FFCR_IDX, 2'h0};
  localparam logic [31:0] PAIR2_MOD_ADDR = {14'h0000, PAIR2_MOD_IDX, 2'h0};

  // flip-flop control register fields
  localparam int FF_SEL_BIT = 0;
  localparam int FF_EN_BIT = 1;
  localparam int FF_CMD_LSB = 2;
  localparam logic [1:0] CMD_INVERT = 2'h0;
  localparam logic [1:0] CMD_SET = 2'h1;
  localparam logic [1:0] CMD_CLEAR = 2'h2;
  localparam logic [1:0] CMD_KEEP = 2'h3;

  // mode register fields
  localparam int LCLK_LSB = 0;
  localparam int UCLK_LSB = 2;
  localparam int PWM_LSB = 4;
  localparam int MODE_LSB = 6;

  localparam logic [1:0] MODE_TWO_8BIT = 2'h0;
  localparam logic [1:0] MODE_CASCADE_16 = 2'h1;
  localparam logic [1:0] MODE_PULSE_GEN = 2'h2;
  localparam logic [1:0] MODE_PWM_TIMER = 2'h3;

  localparam logic [1:0] PWM_RESERVED = 2'h0;
  localparam logic [1:0] PWM_LEN_64 = 2'h1;
  localparam logic [1:0] PWM_LEN_128 = 2'h2;
  localparam logic [1:0] PWM_LEN_256 = 2'h3;
  localparam logic [8:0] PWM_CYCLES_64 = 9'h040;
  localparam logic [8:0] PWM_CYCLES_128 = 9'h080;
  localparam logic [8:0] PWM_CYCLES_256 = 9'h100;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [1:0] cmd;
    logic match_en;
    logic src_sel;
  } tpf_ffcr_type;

  typedef struct packed {
    logic [1:0] pair_mode;
    logic [1:0] pwm_cycle;
    logic [1:0] upper_clk;
    logic [1:0] lower_clk;
  } tpf_mode_type;

  localparam tpf_ffcr_type FFCR_RESET = '{cmd: CMD_KEEP, match_en: 1'b0,
                                          src_sel: 1'b0};
  localparam tpf_mode_type MODE_RESET = '{default: 2'h0};
endpackage : tpf_pkg

// ==== src/tpf_top.sv ====
// Functional notes
// - first pair control bit 0 picks lower (0) or upper (1) match source
// - second pair control bit 0 picks lower (0) or upper (1) match source
// - source choice only counts when the pair runs two 8-bit timers
// - bits 3:2 command: invert, set, clear, keep; field resets to keep
// - bit 1 enables match toggling; resets to disabled
// - bits 4 to 6 read undefined; here they read zero
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module tpf_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] pair0_mode,
  input wire logic [1:0] pair1_mode,
  input wire logic match_a,
  input wire logic match_b,
  input wire logic match_c,
  input wire logic match_d,
  output logic first_output_flipflop,
  output logic second_output_flipflop,
  output tpf_pkg::tpf_mode_type pair2_mode_ctrl,
  output logic [8:0] pwm_period_len
);

  tpf_pkg::tpf_ffcr_type pair0_ffcr_r;
  tpf_pkg::tpf_ffcr_type pair1_ffcr_r;
  tpf_pkg::tpf_mode_type mode_r;
  logic first_ff_r;
  logic second_ff_r;
  logic wr_pend_r;
  logic [31:0] wr_addr_r;
  logic [31:0] rdata_r;
  logic [8:0] pwm_len_r;
  logic addr_ok;
  logic wr0;
  logic wr1;
  logic wr2;
  logic tog0;
  logic tog1;
  logic [1:0] cmd_wr;
  logic first_ff_nxt;
  logic second_ff_nxt;

  // next flip-flop value; an invert, set or clear command wins over a match toggle
  function automatic logic ff_next(input logic cur, input logic wr,
                                   input logic [1:0] cmd, input logic tog);
    logic res;
    res = cur ^ tog;
    if (wr) begin
      case (cmd)
        tpf_pkg::CMD_INVERT: res = ~cur;
        tpf_pkg::CMD_SET: res = 1'b1;
        tpf_pkg::CMD_CLEAR: res = 1'b0;
        default: res = cur ^ tog;
      endcase
    end
    return res;
  endfunction : ff_next

  // match source chosen per pair mode
  function automatic logic match_pick(input logic [1:0] mode,
                                      input logic sel, input logic lower,
                                      input logic upper);
    logic res;
    case (mode)
      tpf_pkg::MODE_TWO_8BIT: res = sel ? upper : lower;
      tpf_pkg::MODE_CASCADE_16: res = upper;
      default: res = lower;
    endcase
    return res;
  endfunction : match_pick

  function automatic logic [7:0] ffcr_read(input tpf_pkg::tpf_ffcr_type f);
    return {4'h0, f};
  endfunction : ffcr_read

  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  assign addr_ok = hsel && hready && (htrans == tpf_pkg::HTRANS_NONSEQ);
  assign wr0 = wr_pend_r && (wr_addr_r == tpf_pkg::PAIR0_FFCR_ADDR);
  assign wr1 = wr_pend_r && (wr_addr_r == tpf_pkg::PAIR1_FFCR_ADDR);
  assign wr2 = wr_pend_r && (wr_addr_r == tpf_pkg::PAIR2_MOD_ADDR);
  assign cmd_wr = hwdata[tpf_pkg::FF_CMD_LSB +: 2];

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr;
    end
  end

  // read data registered in the address phase; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      case (haddr)
        tpf_pkg::PAIR0_FFCR_ADDR: rdata_r <= {24'h0, ffcr_read(pair0_ffcr_r)};
        tpf_pkg::PAIR1_FFCR_ADDR: rdata_r <= {24'h0, ffcr_read(pair1_ffcr_r)};
        tpf_pkg::PAIR2_MOD_ADDR: rdata_r <= {24'h0, mode_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pair0_ffcr_r <= tpf_pkg::FFCR_RESET;
      pair1_ffcr_r <= tpf_pkg::FFCR_RESET;
    end else begin
      if (wr0) begin
        pair0_ffcr_r <= hwdata[3:0];
      end
      if (wr1) begin
        pair1_ffcr_r <= hwdata[3:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_r <= tpf_pkg::MODE_RESET;
    end else if (wr2) begin
      mode_r <= hwdata[7:0];
    end
  end

  assign tog0 = pair0_ffcr_r.match_en &&
                match_pick(pair0_mode, pair0_ffcr_r.src_sel, match_a, match_b);
  assign tog1 = pair1_ffcr_r.match_en &&
                match_pick(pair1_mode, pair1_ffcr_r.src_sel, match_c, match_d);

  // command acts once, on the write itself
  assign first_ff_nxt = ff_next(first_ff_r, wr0, cmd_wr, tog0);
  assign second_ff_nxt = ff_next(second_ff_r, wr1, cmd_wr, tog1);

  always_ff @(posedge clk) begin
    if (reset) begin
      first_ff_r <= 1'b0;
      second_ff_r <= 1'b0;
    end else begin
      first_ff_r <= first_ff_nxt;
      second_ff_r <= second_ff_nxt;
    end
  end

  // PWM cycle length; reserved code gives zero
  always_ff @(posedge clk) begin
    if (reset) begin
      pwm_len_r <= 9'h000;
    end else begin
      case (mode_r.pwm_cycle)
        tpf_pkg::PWM_LEN_64: pwm_len_r <= tpf_pkg::PWM_CYCLES_64;
        tpf_pkg::PWM_LEN_128: pwm_len_r <= tpf_pkg::PWM_CYCLES_128;
        tpf_pkg::PWM_LEN_256: pwm_len_r <= tpf_pkg::PWM_CYCLES_256;
        default: pwm_len_r <= 9'h000;
      endcase
    end
  end

  assign first_output_flipflop = first_ff_r;
  assign second_output_flipflop = second_ff_r;
  assign pair2_mode_ctrl = mode_r;
  assign pwm_period_len = pwm_len_r;

  sw_set_a: assert property (@(posedge clk) disable iff (reset)
    wr0 && cmd_wr == tpf_pkg::CMD_SET |=> first_ff_r)
    else $error("set command did not set first flip-flop");

  sw_clear_a: assert property (@(posedge clk) disable iff (reset)
    wr1 && cmd_wr == tpf_pkg::CMD_CLEAR |=> !second_ff_r)
    else $error("clear command did not clear second flip-flop");

  sw_invert_a: assert property (@(posedge clk) disable iff (reset)
    wr0 && cmd_wr == tpf_pkg::CMD_INVERT |=>
      first_ff_r != $past(first_ff_r))
    else $error("invert command did not invert");

  toggle_off_a: assert property (@(posedge clk) disable iff (reset)
    !pair0_ffcr_r.match_en && !wr0 |=> $stable(first_ff_r))
    else $error("first flip-flop moved with toggling disabled");

  lower_src_a: assert property (@(posedge clk) disable iff (reset)
    !wr0 && pair0_ffcr_r.match_en && !pair0_ffcr_r.src_sel &&
    pair0_mode == tpf_pkg::MODE_TWO_8BIT && match_a
    |=> first_ff_r != $past(first_ff_r))
    else $error("lower match did not toggle first flip-flop");

  upper_src_a: assert property (@(posedge clk) disable iff (reset)
    !wr1 && pair1_ffcr_r.match_en && pair1_ffcr_r.src_sel &&
    pair1_mode == tpf_pkg::MODE_TWO_8BIT && !match_c && match_d
    |=> second_ff_r != $past(second_ff_r))
    else $error("upper match did not toggle second flip-flop");

  sel_ignored_a: assert property (@(posedge clk) disable iff (reset)
    !wr0 && pair0_mode == tpf_pkg::MODE_PULSE_GEN && !match_a
    |=> $stable(first_ff_r))
    else $error("source select honoured outside 8-bit mode");

  read_upper_a: assert property (@(posedge clk) disable iff (reset)
    addr_ok && !hwrite && haddr == tpf_pkg::PAIR1_FFCR_ADDR
    |=> hrdata[31:4] == 28'h0 && hrdata[3:0] == $past(pair1_ffcr_r))
    else $error("flip-flop control read back wrong");

  pwm_len_a: assert property (@(posedge clk) disable iff (reset)
    wr2 && hwdata[tpf_pkg::PWM_LSB +: 2] == tpf_pkg::PWM_LEN_128
    |=> ##1 pwm_period_len == tpf_pkg::PWM_CYCLES_128)
    else $error("PWM cycle length wrong");

  set_second_a: assert property (@(posedge clk) disable iff (reset)
    wr1 && cmd_wr == tpf_pkg::CMD_SET |=> second_ff_r)
    else $error("set command did not set second flip-flop");

  clear_first_a: assert property (@(posedge clk) disable iff (reset)
    wr0 && cmd_wr == tpf_pkg::CMD_CLEAR |=> !first_ff_r)
    else $error("clear command did not clear first flip-flop");

  invert_second_a: assert property (@(posedge clk) disable iff (reset)
    wr1 && cmd_wr == tpf_pkg::CMD_INVERT |=>
      second_ff_r != $past(second_ff_r))
    else $error("invert command did not invert second flip-flop");

  keep_cmd_a: assert property (@(posedge clk) disable iff (reset)
    wr0 && cmd_wr == tpf_pkg::CMD_KEEP && !pair0_ffcr_r.match_en
    |=> $stable(first_ff_r))
    else $error("keep command moved first flip-flop");

  toggle_off_second_a: assert property (@(posedge clk) disable iff (reset)
    !pair1_ffcr_r.match_en && !wr1 |=> $stable(second_ff_r))
    else $error("second flip-flop moved with toggling disabled");

  lower_src_second_a: assert property (@(posedge clk) disable iff (reset)
    !wr1 && pair1_ffcr_r.match_en && !pair1_ffcr_r.src_sel &&
    pair1_mode == tpf_pkg::MODE_TWO_8BIT && match_c
    |=> second_ff_r != $past(second_ff_r))
    else $error("lower match did not toggle second flip-flop");

  upper_src_first_a: assert property (@(posedge clk) disable iff (reset)
    !wr0 && pair0_ffcr_r.match_en && pair0_ffcr_r.src_sel &&
    pair0_mode == tpf_pkg::MODE_TWO_8BIT && !match_a && match_b
    |=> first_ff_r != $past(first_ff_r))
    else $error("upper match did not toggle first flip-flop");

  unsel_quiet_a: assert property (@(posedge clk) disable iff (reset)
    !wr0 && !pair0_ffcr_r.src_sel &&
    pair0_mode == tpf_pkg::MODE_TWO_8BIT && !match_a
    |=> $stable(first_ff_r))
    else $error("unselected match toggled first flip-flop");

  cascade_upper_a: assert property (@(posedge clk) disable iff (reset)
    !wr0 && pair0_ffcr_r.match_en &&
    pair0_mode == tpf_pkg::MODE_CASCADE_16 && match_b
    |=> first_ff_r != $past(first_ff_r))
    else $error("cascade mode did not toggle on upper match");

  pwm_lower_a: assert property (@(posedge clk) disable iff (reset)
    !wr1 && pair1_ffcr_r.match_en &&
    pair1_mode == tpf_pkg::MODE_PWM_TIMER && match_c
    |=> second_ff_r != $past(second_ff_r))
    else $error("PWM mode did not toggle on lower match");

  ffcr_write_a: assert property (@(posedge clk) disable iff (reset)
    wr0 |=> pair0_ffcr_r == $past(hwdata[3:0]))
    else $error("first control register write lost");

  mode_write_a: assert property (@(posedge clk) disable iff (reset)
    wr2 |=> pair2_mode_ctrl == $past(hwdata[7:0]))
    else $error("mode register write lost");

  pwm_long_a: assert property (@(posedge clk) disable iff (reset)
    wr2 && hwdata[tpf_pkg::PWM_LSB +: 2] == tpf_pkg::PWM_LEN_256
    |=> ##1 pwm_period_len == tpf_pkg::PWM_CYCLES_256)
    else $error("PWM cycle length for longest code wrong");

  pwm_rsvd_a: assert property (@(posedge clk) disable iff (reset)
    wr2 && hwdata[tpf_pkg::PWM_LSB +: 2] == tpf_pkg::PWM_RESERVED
    |=> ##1 pwm_period_len == 9'h000)
    else $error("reserved PWM code gave nonzero length");

  read_first_a: assert property (@(posedge clk) disable iff (reset)
    addr_ok && !hwrite && haddr == tpf_pkg::PAIR0_FFCR_ADDR
    |=> hrdata[31:4] == 28'h0 && hrdata[3:0] == $past(pair0_ffcr_r))
    else $error("first control register read back wrong");

  read_mode_a: assert property (@(posedge clk) disable iff (reset)
    addr_ok && !hwrite && haddr == tpf_pkg::PAIR2_MOD_ADDR
    |=> hrdata[31:8] == 24'h0 && hrdata[7:0] == $past(mode_r))
    else $error("mode register read back wrong");

  // no disable here: this one watches the reset itself
  reset_state_a: assert property (@(posedge clk)
    reset |=> pair0_ffcr_r == tpf_pkg::FFCR_RESET && !first_ff_r)
    else $error("control state wrong after reset");

endmodule : tpf_top
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  localparam logic [31:0] AM = tpf_pkg::PAIR2_MOD_ADDR;
  localparam logic [31:0] FFA [0:1] = '{tpf_pkg::PAIR0_FFCR_ADDR,
                                        tpf_pkg::PAIR1_FFCR_ADDR};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [1:0] pair0_mode = 2'h0;
  logic [1:0] pair1_mode = 2'h0;
  logic [3:0] match = 4'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [1:0] ffo;
  tpf_pkg::tpf_mode_type mode_q;
  logic [8:0] pwm_len;
  logic [31:0] rd;
  int error_cnt = 0;
  int n_tests = 0;

  tpf_top dut_u (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pair0_mode(pair0_mode), .pair1_mode(pair1_mode),
    .match_a(match[0]), .match_b(match[1]), .match_c(match[2]),
    .match_d(match[3]), .first_output_flipflop(ffo[0]),
    .second_output_flipflop(ffo[1]), .pair2_mode_ctrl(mode_q),
    .pwm_period_len(pwm_len));

  initial begin
    forever #2 clk = ~clk;
  end

  // entered right after a rising edge; returns at the edge ending data phase
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= tpf_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus

  // extra edge so registered outputs have settled before checks
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    @(posedge clk);
  endtask : wr

  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : chk_rd

  task automatic pulse(input logic [3:0] m);
    match <= m;
    @(posedge clk);
    match <= 4'h0;
    @(posedge clk);
  endtask : pulse

  // unselected match must not toggle, selected one must
  task automatic tog(input int p, input logic [1:0] md, input logic sel,
                     input logic use_up);
    logic b;
    pair0_mode <= md;
    pair1_mode <= md;
    wr(FFA[p], {30'h0000_0003, 1'b1, sel});
    b = ffo[p];
    pulse(use_up ? 4'h1 << (2 * p) : 4'h2 << (2 * p));
    `CHK(ffo[p], b)
    pulse(use_up ? 4'h2 << (2 * p) : 4'h1 << (2 * p));
    `CHK(ffo[p], ~b)
  endtask : tog

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  initial begin
    #40000;
    error_cnt++;
    complete_run();
  end

  initial begin
    logic [31:0] cmds [0:5] = '{32'h4, 32'h8, 32'h0, 32'h0, 32'h4, 32'hC};
    logic [1:0] exps [0:5] = '{2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h1};
    logic [8:0] pwm_exp [0:3] = '{9'h000, tpf_pkg::PWM_CYCLES_64,
      tpf_pkg::PWM_CYCLES_128, tpf_pkg::PWM_CYCLES_256};
    logic [1:0] tmd [0:5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    logic [5:0] tsu = 6'b00_0110;
    logic [5:0] tup = 6'b00_1110;
    logic [7:0] v;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk_rd(FFA[0], 32'h0000_000C);
    chk_rd(FFA[1], 32'h0000_000C);
    chk_rd(AM, 32'h0);
    chk_rd(32'h0000_0100, 32'h0);
    `CHK(hresp, 1'b0)
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 6; i++) begin
        wr(FFA[p], cmds[i]);
        `CHK(ffo[p], exps[i][0])
      end
      chk_rd(FFA[p], 32'h0000_000C);
      pulse(4'hF);
      `CHK(ffo[p], 1'b1)
      for (int k = 0; k < 6; k++) begin
        tog(p, tmd[k], tsu[k] | (k == 1) | (k > 3), tup[k] | (k == 1));
      end
    end
    for (int i = 0; i < 4; i++) begin
      v = {4{i[1:0]}};
      wr(AM, {24'h0, v});
      `CHK(mode_q, v)
      @(posedge clk);
      `CHK(pwm_len, pwm_exp[i])
      chk_rd(AM, {24'h0, v});
    end
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
